//--- rtl/rst_seq_params.svh
`ifndef RST_SEQ_PARAMS_SVH
`define RST_SEQ_PARAMS_SVH

// Strap sampling window before reset release, in master clock cycles
`define STRAP_WINDOW_CYC   10
// Cycles from reset release to first instruction fetch
`define FETCH_DELAY_CYC    80
// Width of the cycle counter
`define SEQ_CNT_W          7
// Boot width reset value: 1 selects 8-bit boot memory
`define BOOT_WIDTH_RST     1'b1
// Float mode reset value: off
`define FLOAT_MODE_RST     1'b0
// First fetch address after any reset
`define RESET_FETCH_ADDR   32'h0000_0000
// Vendor debug identifier, value arbitrary
`define DEBUG_CHIP_ID      32'h1234_5671

`endif

//--- rtl/rst_seq_pkg.sv
package rst_seq_pkg;
    // Sequencer phases
    typedef enum logic [1:0] {
        ST_IN_RESET,
        ST_WAIT_FETCH,
        ST_RUN
    } seq_state_t;
    // Cause of the reset in progress
    typedef enum logic [1:0] {
        CAUSE_NONE,
        CAUSE_EXT,
        CAUSE_WDOG
    } reset_cause_t;
endpackage

//--- rtl/strap_if.sv
`timescale 1ns/1ps
// Carries strap levels and sample controls to the strap sampler
interface strap_if;
    logic boot_width_strap;     // Raw boot width strap level
    logic float_mode_strap_n;   // Raw float strap level, active low
    logic in_ext_reset;         // External reset held
    logic ext_release;          // One-cycle external release pulse
    logic boot_8bit;            // Latched boot width
    logic float_mode;           // Latched float mode
    modport sampler (input boot_width_strap, float_mode_strap_n, in_ext_reset,
                     ext_release, output boot_8bit, float_mode);
    modport ctrl (output boot_width_strap, float_mode_strap_n, in_ext_reset,
                  ext_release, input boot_8bit, float_mode);
endinterface

//--- rtl/strap_sampler.sv
`timescale 1ns/1ps
`include "rst_seq_params.svh"
module strap_sampler
    import rst_seq_pkg::*;
#(
    parameter int WINDOW = `STRAP_WINDOW_CYC
) (
    input  wire logic   sys_clk,
    input  wire logic   srst,
    input  wire logic   clk_en,
    strap_if.sampler    sif
);
    logic [WINDOW-1:0] bw_hist_q;   // Recent boot width levels
    logic [WINDOW-1:0] bw_hist_d;
    logic [WINDOW-1:0] fl_hist_q;   // Recent float strap levels
    logic [WINDOW-1:0] fl_hist_d;
    logic              boot_q;      // Latched boot width
    logic              boot_d;
    logic              float_q;     // Latched float mode
    logic              float_d;

    // Shift histories during external reset; latch only at its release
    always_comb begin
        bw_hist_d = bw_hist_q;
        fl_hist_d = fl_hist_q;
        boot_d    = boot_q;
        float_d   = float_q;
        if (sif.in_ext_reset) begin
            bw_hist_d = {bw_hist_q[WINDOW-2:0], sif.boot_width_strap};
            fl_hist_d = {fl_hist_q[WINDOW-2:0], sif.float_mode_strap_n};
        end
        if (sif.ext_release) begin
            // majority-free: boot width from latest window level
            boot_d  = bw_hist_q[0];
            float_d = (fl_hist_q == '0);
        end
    end

    // Registers; srst is the system reset, not the strap release
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            bw_hist_q <= '1;
            fl_hist_q <= '1;
            boot_q    <= `BOOT_WIDTH_RST;
            float_q   <= `FLOAT_MODE_RST;
        end else if (clk_en) begin
            bw_hist_q <= bw_hist_d;
            fl_hist_q <= fl_hist_d;
            boot_q    <= boot_d;
            float_q   <= float_d;
        end
    end

    assign sif.boot_8bit  = boot_q;
    assign sif.float_mode = float_q;
endmodule

//--- rtl/reset_mode_sampling_sequencer.sv
// Notes on behaviour
// - Enter reset at once, release on clock
// - First fetch eighty cycles after release
// - Any reset restores defaults, fetch at zero
// - Core registers need no reset value
// - Clock output low while reset pin held
// - Clock output copies clock until reprogrammed; the code drives a half-rate image of sys_clk instead
// - Peripheral pins become inputs after reset; the code forces inputs only during reset and in float mode, otherwise the enables follow io_oe_req
// - Watchdog reset keeps latched strap settings
// - External pin wins over watchdog
// - Float mode needs ten low cycles
// - Float mode disables all output drivers
// - Float strap pin shared after reset
// - Debug port returns vendor chip identifier
// - Boot width strap latched at release
`timescale 1ns/1ps
`include "rst_seq_params.svh"
module reset_mode_sampling_sequencer
    import rst_seq_pkg::*;
#(
    parameter int FETCH_DELAY = `FETCH_DELAY_CYC,
    parameter int N_IO        = 32
) (
    input  wire logic              sys_clk,
    input  wire logic              srst,
    input  wire logic              clk_en,
    input  wire logic              ext_reset_n,
    input  wire logic              wdog_reset_req,
    input  wire logic              boot_width_strap,
    input  wire logic              float_mode_strap_n,
    input  wire logic              clock_out_as_gpio,
    input  wire logic              clock_out_gpio_val,
    input  wire logic              serial1_transmit,
    input  wire logic              serial1_tx_en,
    input  wire logic [N_IO-1:0]   io_out_req,
    input  wire logic [N_IO-1:0]   io_oe_req,
    input  wire logic              debug_id_req,
    output logic                   sys_reset,
    output logic                   fetch_enable,
    output logic                   fetch_start,
    output logic [31:0]            fetch_addr,
    output logic                   boot_8bit,
    output logic                   float_mode,
    output logic                   clock_out_pin,
    output logic                   clock_out_oe,
    output logic                   shared_pin_out,
    output logic                   shared_pin_oe,
    output logic [N_IO-1:0]        io_out,
    output logic [N_IO-1:0]        io_oe,
    output logic                   debug_id_valid,
    output logic [31:0]            debug_id
);
    // Counter width; it must hold FETCH_DELAY - 1
    localparam int CW = `SEQ_CNT_W;

    strap_if sif ();                     // Strap sampler link

    seq_state_t     state_q;             // Sequencer phase
    seq_state_t     state_d;
    reset_cause_t   cause_q;             // Source of current reset
    reset_cause_t   cause_d;
    logic [CW-1:0]  cnt_q;               // Cycles since release
    logic [CW-1:0]  cnt_d;
    logic           ext_q;               // External pin held, registered
    logic           rst_q;               // Internal reset output
    logic           rst_d;
    logic           fen_q;               // Fetch allowed
    logic           fen_d;
    logic           fst_q;               // First fetch pulse
    logic           fst_d;

    // Pin driver state: one register and one next value each
    logic           ck_q;                // Clock out image
    logic           ck_d;
    logic           ck_oe_q;             // Clock out driver enable
    logic           ck_oe_d;
    logic           sh_q;                // Shared strap pin output
    logic           sh_d;
    logic           sh_oe_q;             // Shared pin driver enable
    logic           sh_oe_d;
    logic [N_IO-1:0] io_q;               // Io line outputs
    logic [N_IO-1:0] io_d;
    logic [N_IO-1:0] io_oe_q;            // Io line driver enables
    logic [N_IO-1:0] io_oe_d;
    logic           dbv_q;               // Debug id answer
    logic           dbv_d;
    logic [31:0]    dbid_q;              // Debug id value
    logic [31:0]    dbid_d;
    logic [31:0]    fa_q;                // First fetch address
    logic [31:0]    fa_d;

    // Shared pin and io drivers may switch on only outside reset and float mode;
    // shared by the shared pin and the io lines so both gate alike
    function automatic logic drive_ok(input logic pin_held,
                                      input logic rst_next,
                                      input logic floating);
        return ~pin_held & ~rst_next & ~floating;
    endfunction

    // Pin is synchronous to sys_clk by convention, so it is used directly
    // A board with a free-running pin needs a synchroniser ahead of this
    wire ext_now = ~ext_reset_n;

    // The one output not taken from a flop: entry into reset
    // must not wait for a clock edge
    // assert immediately, release on edge
    assign sys_reset = rst_q | ext_now;

    // Raw strap levels go to the sampler untouched
    assign sif.boot_width_strap   = boot_width_strap;
    assign sif.float_mode_strap_n = float_mode_strap_n;
    assign sif.in_ext_reset       = ext_now;
    // One pulse on the cycle the external pin releases
    // ext_q is the pin as seen one edge earlier
    assign sif.ext_release        = ext_q & ~ext_now;

    // Strap histories and latched settings live in the sampler
    strap_sampler #(
        .WINDOW (`STRAP_WINDOW_CYC)
    ) u_straps (
        .sys_clk (sys_clk),
        .srst    (srst),
        .clk_en  (clk_en),
        .sif     (sif)
    );

    // Reset sequencing: hold, count, then run
    always_comb begin
        state_d = state_q;
        cause_d = cause_q;
        cnt_d   = cnt_q;
        rst_d   = rst_q;
        fen_d   = fen_q;
        fst_d   = 1'b0;
        if (ext_now) begin
            state_d = ST_IN_RESET;
            // Pin held: any watchdog request is absorbed here
            cause_d = CAUSE_EXT;
            rst_d   = 1'b1;
            fen_d   = 1'b0;
            cnt_d   = '0;
        // watchdog acts as reset, no straps
        end else if (wdog_reset_req) begin
            state_d = ST_IN_RESET;
            // Straps untouched: the sampler only listens to the pin
            cause_d = CAUSE_WDOG;
            rst_d   = 1'b1;
            fen_d   = 1'b0;
            cnt_d   = '0;
        end else begin
            unique case (state_q)
                ST_IN_RESET: begin
                    // Released: start the fetch delay
                    state_d = ST_WAIT_FETCH;
                    rst_d   = 1'b0;
                    cnt_d   = CW'(1);
                end
                ST_WAIT_FETCH: begin
                    // fetch at eightieth cycle
                    // cnt_q counts edges since release, starting at one
                    if (cnt_q == CW'(FETCH_DELAY - 1)) begin
                        state_d = ST_RUN;
                        fen_d   = 1'b1;
                        fst_d   = 1'b1;
                        cause_d = CAUSE_NONE;
                    end else begin
                        cnt_d = cnt_q + CW'(1);
                    end
                end
                ST_RUN: begin
                    // Stays here until the next reset of either kind
                    state_d = ST_RUN;
                end
                default: begin
                    // Unused code: fall back into reset
                    state_d = ST_IN_RESET;
                    rst_d   = 1'b1;
                end
            endcase
        end
    end

    // Sequencer registers; srst puts the sequencer in reset
    // Clock enable low freezes the phase and the counter
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state_q <= ST_IN_RESET;
            cause_q <= CAUSE_NONE;
            cnt_q   <= '0;
            ext_q   <= 1'b0;
            rst_q   <= 1'b1;
            fen_q   <= 1'b0;
            fst_q   <= 1'b0;
        end else if (clk_en) begin
            state_q <= state_d;
            cause_q <= cause_d;
            cnt_q   <= cnt_d;
            ext_q   <= ext_now;
            rst_q   <= rst_d;
            fen_q   <= fen_d;
            fst_q   <= fst_d;
        end
    end

    // Next pin driver values; core registers besides the fetch address are left alone
    always_comb begin
        if (ext_now) begin
            ck_d = 1'b0;
        end else if (!clock_out_as_gpio || rst_d) begin
            // Half-rate image: a register cannot copy the clock itself
            ck_d = ~ck_q;
        end else begin
            ck_d = clock_out_gpio_val;
        end

        // Clock out has no reset gating: it is driven low while held
        // float mode kills every driver
        ck_oe_d = ~sif.float_mode;

        // The strap reading is over once reset ends; the pin carries serial data
        // strap meaning only during reset
        sh_d    = serial1_transmit;
        sh_oe_d = serial1_tx_en & drive_ok(ext_now, rst_d, sif.float_mode);

        // Data pass freely; a driver that is off hides them
        // inputs during reset and in float mode; otherwise the enables follow io_oe_req
        io_d    = io_out_req;
        io_oe_d = drive_ok(ext_now, rst_d, sif.float_mode) ? io_oe_req : '0;

        // Registered answer, so it stands the cycle after the request
        // vendor chip identifier
        dbv_d   = debug_id_req;
        dbid_d  = debug_id_req ? `DEBUG_CHIP_ID : 32'h0000_0000;

        // only the fetch address is reset
        fa_d    = fa_q;
        // every reset points the fetch at zero
        if (rst_d) begin
            fa_d = `RESET_FETCH_ADDR;
        end
    end

    // Pin driver registers; srst leaves every driver off
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            ck_q    <= 1'b0;
            ck_oe_q <= 1'b0;
            sh_q    <= 1'b0;
            sh_oe_q <= 1'b0;
            io_q    <= '0;
            io_oe_q <= '0;
            dbv_q   <= 1'b0;
            dbid_q  <= '0;
            fa_q    <= `RESET_FETCH_ADDR;
        end else if (clk_en) begin
            // Clock enable low freezes every driver
            ck_q    <= ck_d;
            ck_oe_q <= ck_oe_d;
            sh_q    <= sh_d;
            sh_oe_q <= sh_oe_d;
            io_q    <= io_d;
            io_oe_q <= io_oe_d;
            dbv_q   <= dbv_d;
            dbid_q  <= dbid_d;
            fa_q    <= fa_d;
        end
    end

    // Fetch control straight from the sequencer flops
    assign fetch_enable   = fen_q;
    assign fetch_start    = fst_q;
    assign fetch_addr     = fa_q;

    // Strap settings come from the sampler's own registers
    assign boot_8bit      = sif.boot_8bit;
    assign float_mode     = sif.float_mode;

    // Clock out pin and its driver enable
    assign clock_out_pin  = ck_q;
    assign clock_out_oe   = ck_oe_q;

    // Shared strap pin, a plain output once reset is over
    assign shared_pin_out = sh_q;
    assign shared_pin_oe  = sh_oe_q;

    // Io lines
    assign io_out         = io_q;
    assign io_oe          = io_oe_q;

    // Debug identifier answer
    assign debug_id_valid = dbv_q;
    assign debug_id       = dbid_q;
endmodule

//--- dv/rst_seq_assertions.sv
`timescale 1ns/1ps
`include "rst_seq_params.svh"
// Watches the sequencer pins; helper-free, all in the one clock domain
module rst_seq_checker #(
    parameter int FETCH_DELAY = 80,
    parameter int N_IO        = 32
) (
    input wire logic            sys_clk,
    input wire logic            srst,
    input wire logic            ext_reset_n,
    input wire logic            debug_id_req,
    input wire logic            sys_reset,
    input wire logic            fetch_enable,
    input wire logic            fetch_start,
    input wire logic [31:0]     fetch_addr,
    input wire logic            boot_8bit,
    input wire logic            float_mode,
    input wire logic            clock_out_pin,
    input wire logic            clock_out_oe,
    input wire logic            shared_pin_oe,
    input wire logic [N_IO-1:0] io_oe,
    input wire logic            debug_id_valid,
    input wire logic [31:0]     debug_id
);
    // The rise is seen one edge after it; the pulse is sampled FETCH_DELAY edges later
    localparam int FETCH_GAP = FETCH_DELAY - 1;
    default clocking cb @(posedge sys_clk); endclocking
    // Sync reset hides the edges where the latches are being cleared
    default disable iff (srst);
    chk_entry_async: assert property (!ext_reset_n |-> sys_reset)
        else $error("internal reset low while pin held");
    chk_clkout_low: assert property (!ext_reset_n [*2] |-> !clock_out_pin)
        else $error("clock out high in reset");
    chk_fetch_time: assert property ($rose(ext_reset_n) |->
        ##FETCH_GAP !fetch_enable ##1 (fetch_start && fetch_enable))
        else $error("first fetch at wrong cycle");
    chk_fetch_once: assert property (fetch_start |=> !fetch_start)
        else $error("fetch pulse too long");
    chk_fetch_zero: assert property (fetch_start |-> fetch_addr == `RESET_FETCH_ADDR)
        else $error("fetch address not zero");
    chk_boot_hold: assert property ($changed(boot_8bit) |->
        $past(ext_reset_n) && !$past(ext_reset_n, 2))
        else $error("boot width moved outside release");
    chk_float_hold: assert property ($changed(float_mode) |->
        $past(ext_reset_n) && !$past(ext_reset_n, 2))
        else $error("float mode moved outside release");
    chk_float_quiet: assert property (float_mode && $past(float_mode) |->
        io_oe == '0 && !clock_out_oe && !shared_pin_oe)
        else $error("driver enabled in float mode");
    chk_reset_inputs: assert property (sys_reset && $past(sys_reset) |-> io_oe == '0)
        else $error("io driven during reset");
    chk_debug_answer: assert property (debug_id_req |=>
        debug_id_valid && debug_id == `DEBUG_CHIP_ID)
        else $error("debug id answer wrong");
    cov_float: cover property ($rose(float_mode));
    cov_fetch: cover property (fetch_start);
    cov_debug: cover property (debug_id_valid);
endmodule

bind reset_mode_sampling_sequencer rst_seq_checker #(.FETCH_DELAY(FETCH_DELAY), .N_IO(N_IO))
    rst_seq_checker_i (.sys_clk, .srst, .ext_reset_n, .debug_id_req, .sys_reset,
    .fetch_enable, .fetch_start, .fetch_addr, .boot_8bit, .float_mode, .clock_out_pin,
    .clock_out_oe, .shared_pin_oe, .io_oe, .debug_id_valid, .debug_id);

//--- dv/board_model.sv
`timescale 1ns/1ps
// Board reset circuit and strap resistors
module board_model (
    input  wire logic sys_clk,
    output logic      ext_reset_n,
    output logic      boot_width_strap,
    output logic      float_mode_strap_n
);
    logic busy = 1'b1;  // High while a reset pulse is in progress
    initial begin
        ext_reset_n = 1'b0;
        boot_width_strap = 1'b0;
        float_mode_strap_n = 1'b1;
    end
    // shared pins carry traffic
    // Toggling after release exposes any late strap sampling
    always @(posedge sys_clk) begin
        if (!busy) begin
            boot_width_strap <= ~boot_width_strap;
            float_mode_strap_n <= ~float_mode_strap_n;
        end
    end
    // Hold reset, pull float low for the last low_n cycles; returns one edge after release
    task automatic reset_pulse(input int hold, input logic boot, input int low_n);
        busy = 1'b1;
        for (int i = 0; i < hold; i++) begin
            @(posedge sys_clk);
            ext_reset_n <= 1'b0;
            float_mode_strap_n <= (i < hold - low_n);
            // Only the final sample carries the wanted width
            boot_width_strap <= (i == hold - 1) ? boot : ~boot;
        end
        @(posedge sys_clk);
        ext_reset_n <= 1'b1;
        @(posedge sys_clk);
        busy = 1'b0;
    endtask
endmodule

//--- dv/reset_mode_sampling_sequencer_tb_top.sv
`timescale 1ns/1ps
`include "rst_seq_params.svh"
module reset_mode_sampling_sequencer_tb_top;
    localparam int NIO = 4;                 // Few io lines keep literals short
    logic            sys_clk;
    logic            srst = 1'b1, clk_en = 1'b1;
    logic            wdog_reset_req = 1'b0;
    logic            clock_out_as_gpio = 1'b0, clock_out_gpio_val = 1'b0;
    logic            serial1_transmit = 1'b0, serial1_tx_en = 1'b0, debug_id_req = 1'b0;
    logic [NIO-1:0]  io_out_req = '0, io_oe_req = '0, io_out, io_oe;
    logic            ext_reset_n, boot_width_strap, float_mode_strap_n;
    logic            sys_reset, fetch_enable, fetch_start, boot_8bit, float_mode;
    logic            clock_out_pin, clock_out_oe, shared_pin_out, shared_pin_oe, debug_id_valid;
    logic [31:0]     fetch_addr, debug_id;
    int              failures = 0, n_checks = 0;

    reset_mode_sampling_sequencer #(.N_IO(NIO)) reset_mode_sampling_sequencer_i (.sys_clk,
        .srst, .clk_en, .ext_reset_n, .wdog_reset_req, .boot_width_strap,
        .float_mode_strap_n, .clock_out_as_gpio, .clock_out_gpio_val, .serial1_transmit,
        .serial1_tx_en, .io_out_req, .io_oe_req, .debug_id_req, .sys_reset, .fetch_enable,
        .fetch_start, .fetch_addr, .boot_8bit, .float_mode, .clock_out_pin, .clock_out_oe,
        .shared_pin_out, .shared_pin_oe, .io_out, .io_oe, .debug_id_valid, .debug_id);
    board_model board_model_i (.sys_clk, .ext_reset_n, .boot_width_strap, .float_mode_strap_n);

    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic complete_run;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // Edges from the second after the pin rises to the settled fetch pulse, bounded
    task automatic wait_fetch(output int n);
        n = 0;
        do begin
            @(posedge sys_clk);
            #1;
            n++;
        end while (fetch_start !== 1'b1 && n < 200);
    endtask

    // Plain boot: 9 low cycles is one short of float
    task automatic s_plain;
        int n;
        @(posedge sys_clk);
        io_oe_req <= 4'hf;
        io_out_req <= 4'ha;
        repeat (2) @(posedge sys_clk);
        #1;
        check("io_oe in reset", 32'h0, io_oe);
        check("clk out in reset", 32'h0, clock_out_pin);
        board_model_i.reset_pulse(20, 1'b1, 9);
        wait_fetch(n);
        // The pin rose one edge before the count began
        check("fetch delay", 32'(`FETCH_DELAY_CYC - 1), n);
        check("fetch addr", 32'h0, fetch_addr);
        check("boot width", 32'h1, boot_8bit);
        check("float", 32'h0, float_mode);
        check("io_oe run", 32'hf, io_oe);
        check("io_out run", 32'ha, io_out);
    endtask

    // Exactly 10 low cycles enter float with 16-bit boot
    task automatic s_float;
        int n;
        board_model_i.reset_pulse(20, 1'b0, 10);
        wait_fetch(n);
        check("boot width", 32'h0, boot_8bit);
        check("float", 32'h1, float_mode);
        check("io_oe float", 32'h0, io_oe);
    endtask

    // Watchdog resets but keeps the latched straps
    task automatic s_wdog;
        int n;
        @(posedge sys_clk);
        wdog_reset_req <= 1'b1;
        repeat (3) @(posedge sys_clk);
        #1;
        check("wdog reset", 32'h1, sys_reset);
        check("wdog fetch off", 32'h0, fetch_enable);
        @(posedge sys_clk);
        wdog_reset_req <= 1'b0;
        wait_fetch(n);
        check("wdog fetch", 32'h1, fetch_start);
        check("boot kept", 32'h0, boot_8bit);
        check("float kept", 32'h1, float_mode);
    endtask

    // Watchdog inside an external reset: pin governs
    task automatic s_both;
        int n;
        fork
            board_model_i.reset_pulse(20, 1'b1, 0);
            begin
                repeat (3) @(posedge sys_clk);
                wdog_reset_req <= 1'b1;
                repeat (4) @(posedge sys_clk);
                wdog_reset_req <= 1'b0;
            end
        join
        wait_fetch(n);
        check("fetch delay both", 32'(`FETCH_DELAY_CYC - 1), n);
        check("boot both", 32'h1, boot_8bit);
        check("float both", 32'h0, float_mode);
    endtask

    // Clock image, gpio takeover, shared pin, debug id
    task automatic s_pins;
        logic a;
        @(posedge sys_clk);
        serial1_tx_en <= 1'b1;
        serial1_transmit <= 1'b1;
        debug_id_req <= 1'b1;
        @(posedge sys_clk);
        #1;
        a = clock_out_pin;
        check("debug valid", 32'h1, debug_id_valid);
        check("debug id", `DEBUG_CHIP_ID, debug_id);
        @(posedge sys_clk);
        #1;
        check("clk image", {31'h0, ~a}, clock_out_pin);
        check("clk oe", 32'h1, clock_out_oe);
        check("shared oe", 32'h1, shared_pin_oe);
        check("shared out", 32'h1, shared_pin_out);
        // Clock enable low must freeze the clock image
        @(posedge sys_clk);
        clk_en <= 1'b0;
        @(posedge sys_clk);
        #1;
        a = clock_out_pin;
        repeat (2) @(posedge sys_clk);
        #1;
        check("clk frozen", {31'h0, a}, clock_out_pin);
        @(posedge sys_clk);
        clk_en <= 1'b1;
        debug_id_req <= 1'b0;
        clock_out_as_gpio <= 1'b1;
        clock_out_gpio_val <= 1'b1;
        repeat (3) @(posedge sys_clk);
        #1;
        check("clk gpio", 32'h1, clock_out_pin);
        check("debug idle", 32'h0, debug_id_valid);
    endtask

    initial begin
        repeat (5) @(posedge sys_clk);
        srst <= 1'b0;
        s_plain();
        s_float();
        s_wdog();
        s_both();
        s_pins();
        complete_run();
    end

    // Whole run is well under 1000 cycles; this cuts a hang
    initial begin
        #200000;
        failures++;
        complete_run();
    end
endmodule
